// [src/asel_defs.svh]
`ifndef ASEL_DEFS_SVH
`define ASEL_DEFS_SVH

// ----------------------------------------------------------------------
// Clock and rate limits.
// ----------------------------------------------------------------------
`define ASEL_CLK_HZ       50000000
`define ASEL_RATE_MIN_HZ  25000
`define ASEL_RATE_MAX_HZ  105000
`define ASEL_WCLK_MAX_HZ  103000
`define ASEL_PW           12
`define ASEL_PER_MAX      12'(`ASEL_CLK_HZ / `ASEL_RATE_MIN_HZ)
`define ASEL_PER_MIN \
   12'((`ASEL_CLK_HZ + `ASEL_RATE_MAX_HZ - 1) / `ASEL_RATE_MAX_HZ)
`define ASEL_WCLK_PER_MIN \
   12'((`ASEL_CLK_HZ + `ASEL_WCLK_MAX_HZ - 1) / `ASEL_WCLK_MAX_HZ)
`define ASEL_PER_IDLE     12'hfff
`define ASEL_SYNC_TOL     12'h004

// ----------------------------------------------------------------------
// Playback sample rates.
// ----------------------------------------------------------------------
`define ASEL_FS_32K       32000
`define ASEL_FS_44K       44100
`define ASEL_FS_48K       48000
`define ASEL_FS_88K       88200
`define ASEL_FS_96K       96000

// ----------------------------------------------------------------------
// Register map and fields.
// ----------------------------------------------------------------------
`define ASEL_REG_CTRL     5'h00
`define ASEL_REG_REF      5'h04
`define ASEL_REG_SYNC     5'h08
`define ASEL_REG_IRQ_ST   5'h0c
`define ASEL_REG_IRQ_MASK 5'h10
`define ASEL_CTRL_AUTO    0
`define ASEL_CTRL_PREF    1
`define ASEL_CTRL_RATE    4
`define ASEL_REF_SLAVE    3
`define ASEL_REF_PAIR     4
`define ASEL_REF_PER      16
`define ASEL_IRQ_REF      0
`define ASEL_IRQ_MODE     1
`define ASEL_IRQ_SYNC     2
`define ASEL_IRQ_W        3
`define ASEL_NSRC         6
`define ASEL_SCAN_LAST    3'h5

`endif

// [src/asel_pkg.sv]
package asel_pkg;

   typedef enum logic [1:0] {
      ASEL_MASTER = 2'h0,
      ASEL_SCAN   = 2'h1,
      ASEL_FOLLOW = 2'h3
   } asel_state_t;

   typedef enum logic [2:0] {
      ASEL_OPT1  = 3'h0,
      ASEL_OPT2  = 3'h1,
      ASEL_OPT3  = 3'h2,
      ASEL_SPDIF = 3'h3,
      ASEL_WCLK  = 3'h4,
      ASEL_SYNCP = 3'h5,
      ASEL_NONE  = 3'h7
   } asel_src_t;

   typedef enum logic [1:0] {
      ASEL_NO_LOCK = 2'h0,
      ASEL_LOCKED  = 2'h1,
      ASEL_IN_SYNC = 2'h3
   } asel_lock_t;

   typedef enum logic [2:0] {
      ASEL_FS32 = 3'h0,
      ASEL_FS44 = 3'h1,
      ASEL_FS48 = 3'h2,
      ASEL_FS88 = 3'h3,
      ASEL_FS96 = 3'h4
   } asel_rate_t;

endpackage : asel_pkg

// [src/asel_rate_meter.sv]
`timescale 1ns/1ps
`include "asel_defs.svh"

module asel_rate_meter #(
   parameter logic [11:0] MIN_PER = `ASEL_PER_MIN
) (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        link_in,
   output logic             valid,
   output logic [11:0]      period
);
   import asel_pkg::*;

   logic [2:0]  sync_q;
   logic [11:0] cnt;
   logic        rise;

   assign rise = sync_q[1] & ~sync_q[2];

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sync_q <= 3'h0;
      end else begin
         sync_q <= {sync_q[1:0], link_in};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cnt <= `ASEL_PER_IDLE;
      end else if (rise) begin
         cnt <= 12'h001;
      end else if (cnt <= `ASEL_PER_MAX) begin
         cnt <= cnt + 12'h001;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         valid  <= 1'b0;
         period <= 12'h000;
      end else if (rise) begin
         valid  <= (cnt >= MIN_PER) && (cnt <= `ASEL_PER_MAX);
         period <= cnt;
      end else if (cnt > `ASEL_PER_MAX) begin
         valid  <= 1'b0;
      end
   end

   AST_RATE_RANGE: assert property (
      @(posedge sys_clk) disable iff (rst)
      valid |-> (period >= MIN_PER) && (period <= `ASEL_PER_MAX))
      else $error("Valid flag with a period outside the range.");

   AST_RATE_TIMEOUT: assert property (
      @(posedge sys_clk) disable iff (rst)
      (cnt > `ASEL_PER_MAX) && !rise |=> !valid)
      else $error("Valid flag kept after the input stopped.");

endmodule : asel_rate_meter

// [src/asel_sync_class.sv]
`timescale 1ns/1ps
`include "asel_defs.svh"

module asel_sync_class (
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   input  wire logic                 valid,
   input  wire logic [11:0]          period,
   input  wire logic [11:0]          expect_per,
   output asel_pkg::asel_lock_t      lock_state
);
   import asel_pkg::*;

   logic [11:0] diff;

   assign diff = (period > expect_per) ? period - expect_per
                                       : expect_per - period;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         lock_state <= ASEL_NO_LOCK;
      end else if (!valid) begin
         lock_state <= ASEL_NO_LOCK;
      end else if (diff <= `ASEL_SYNC_TOL) begin
         lock_state <= ASEL_IN_SYNC;
      end else begin
         lock_state <= ASEL_LOCKED;
      end
   end

   AST_NO_LOCK: assert property (@(posedge sys_clk) disable iff (rst)
      !valid |=> lock_state == ASEL_NO_LOCK)
      else $error("Lock reported without a valid input.");

endmodule : asel_sync_class

// [src/asel_source_selector.sv]
// Chosen here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "asel_defs.svh"

module asel_source_selector (
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   input  wire logic [4:0]           avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [31:0]          avs_writedata,
   input  wire logic [3:0]           avs_byteenable,
   output logic [31:0]               avs_readdata,
   output logic                      avs_waitrequest,
   input  wire logic                 optical_input_one,
   input  wire logic                 optical_input_two,
   input  wire logic                 optical_input_three,
   input  wire logic                 spdif_in,
   input  wire logic                 word_clock_in,
   input  wire logic                 sync_port,
   output logic                      irq,
   output logic                      clk_slave,
   output asel_pkg::asel_src_t       active_reference_report,
   output logic [11:0]               ref_period,
   output logic [11:0]               per_input_sync_monitor,
   output logic                      pairing_mode
);
   import asel_pkg::*;

   // -------------------------------------------------------------------
   // Decoding helpers.
   // -------------------------------------------------------------------
   function automatic asel_src_t next_src(input asel_src_t s);
      next_src = (s >= ASEL_SYNCP) ? ASEL_OPT1 : asel_src_t'(s + 3'h1);
   endfunction : next_src

   function automatic logic is_opt(input logic [2:0] s);
      is_opt = (s <= ASEL_OPT3);
   endfunction : is_opt

   function automatic logic src_ok(input logic [2:0] s);
      src_ok = (s <= ASEL_SYNCP);
   endfunction : src_ok

   function automatic logic [11:0] rate_per(input asel_rate_t r);
      unique case (r)
         ASEL_FS32: rate_per = 12'(`ASEL_CLK_HZ / `ASEL_FS_32K);
         ASEL_FS44: rate_per = 12'(`ASEL_CLK_HZ / `ASEL_FS_44K);
         ASEL_FS48: rate_per = 12'(`ASEL_CLK_HZ / `ASEL_FS_48K);
         ASEL_FS88: rate_per = 12'(`ASEL_CLK_HZ / `ASEL_FS_88K);
         ASEL_FS96: rate_per = 12'(`ASEL_CLK_HZ / `ASEL_FS_96K);
         default:   rate_per = 12'(`ASEL_CLK_HZ / `ASEL_FS_48K);
      endcase
   endfunction : rate_per

   // -------------------------------------------------------------------
   // Declarations.
   // -------------------------------------------------------------------
   logic                auto_follow_mode;
   asel_src_t           pref_ref;
   asel_rate_t          rate_sel;
   logic [2:0]          irq_mask;
   logic [2:0]          irq_status;
   asel_state_t         state;
   asel_src_t           cursor;
   logic [2:0]          visited;
   logic [5:0]          pins;
   logic [5:0]          in_valid;
   logic [11:0]         in_period [6];
   logic [11:0]         sys_per;
   logic [11:0]         act_per;
   logic                act_sync;
   logic                pref_ok;
   logic                next_pair;
   logic                wr_en;
   logic [31:0]         rd_word;
   asel_src_t           ref_q;
   logic                slave_q;
   logic [11:0]         mon_q;
   logic [2:0]          events;

   assign pins = {sync_port, word_clock_in, spdif_in,
                  optical_input_three, optical_input_two,
                  optical_input_one};
   assign pref_ok  = src_ok(pref_ref);
   assign sys_per  = rate_per(rate_sel);
   assign wr_en    = avs_write & ~avs_waitrequest & avs_byteenable[0];
   assign act_per  = src_ok(active_reference_report)
                     ? in_period[active_reference_report] : 12'h000;
   assign act_sync = src_ok(active_reference_report)
      && (per_input_sync_monitor[2*active_reference_report +: 2]
          == ASEL_IN_SYNC);
   assign next_pair = pref_ok && is_opt(pref_ref)
      && ((rate_sel == ASEL_FS88) || (rate_sel == ASEL_FS96));

   // -------------------------------------------------------------------
   // Input measurement and sync monitor.
   // -------------------------------------------------------------------
   for (genvar g = 0; g < `ASEL_NSRC; g++) begin : g_in
      localparam logic [11:0] MINP = (g == ASEL_WCLK)
         ? `ASEL_WCLK_PER_MIN : `ASEL_PER_MIN;
      logic [11:0] expect_per;

      assign expect_per = (is_opt(3'(g)) && pairing_mode)
         ? 12'(sys_per << 1) : sys_per;

      asel_rate_meter #(
         .MIN_PER (MINP)
      ) u_meter (
         .sys_clk (sys_clk),
         .rst     (rst),
         .link_in (pins[g]),
         .valid   (in_valid[g]),
         .period  (in_period[g])
      );

      asel_sync_class u_class (
         .sys_clk    (sys_clk),
         .rst        (rst),
         .valid      (in_valid[g]),
         .period     (in_period[g]),
         .expect_per (expect_per),
         .lock_state (per_input_sync_monitor[2*g +: 2])
      );
   end

   // -------------------------------------------------------------------
   // Reference selection.
   // -------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state                   <= ASEL_MASTER;
         cursor                  <= ASEL_OPT1;
         visited                 <= 3'h0;
         active_reference_report <= ASEL_NONE;
      end else if (!auto_follow_mode) begin
         state                   <= ASEL_MASTER;
         active_reference_report <= ASEL_NONE;
      end else begin
         unique case (state)
            ASEL_MASTER: begin
               state   <= ASEL_SCAN;
               cursor  <= pref_ok ? pref_ref : ASEL_OPT1;
               visited <= 3'h0;
               active_reference_report <= ASEL_NONE;
            end
            ASEL_SCAN: begin
               if (in_valid[cursor]) begin
                  state                   <= ASEL_FOLLOW;
                  active_reference_report <= cursor;
               end else if (visited == `ASEL_SCAN_LAST) begin
                  state <= ASEL_MASTER;
               end else begin
                  cursor  <= next_src(cursor);
                  visited <= visited + 3'h1;
               end
            end
            ASEL_FOLLOW: begin
               if (pref_ok && (pref_ref != active_reference_report)
                   && in_valid[pref_ref]) begin
                  active_reference_report <= pref_ref;
               end else if (!in_valid[active_reference_report]) begin
                  state   <= ASEL_SCAN;
                  cursor  <= pref_ok ? pref_ref
                             : next_src(active_reference_report);
                  visited <= 3'h0;
                  active_reference_report <= ASEL_NONE;
               end
            end
            default: begin
               state <= ASEL_MASTER;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Clock mode and reference report.
   // -------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         clk_slave    <= 1'b0;
         ref_period   <= 12'h000;
         pairing_mode <= 1'b0;
      end else begin
         clk_slave    <= auto_follow_mode && (state == ASEL_FOLLOW)
                         && act_sync;
         ref_period   <= act_per;
         pairing_mode <= next_pair;
      end
   end

   // -------------------------------------------------------------------
   // Interrupts.
   // -------------------------------------------------------------------
   assign events = {per_input_sync_monitor != mon_q,
                    clk_slave != slave_q,
                    active_reference_report != ref_q};

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ref_q      <= ASEL_NONE;
         slave_q    <= 1'b0;
         mon_q      <= 12'h000;
         irq_status <= 3'h0;
         irq        <= 1'b0;
      end else begin
         ref_q      <= active_reference_report;
         slave_q    <= clk_slave;
         mon_q      <= per_input_sync_monitor;
         if (wr_en && (avs_address == `ASEL_REG_IRQ_ST)) begin
            irq_status <= (irq_status
                          & ~avs_writedata[`ASEL_IRQ_W-1:0]) | events;
         end else begin
            irq_status <= irq_status | events;
         end
         irq <= |(irq_status & irq_mask);
      end
   end

   // -------------------------------------------------------------------
   // Register bus.
   // -------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         auto_follow_mode <= 1'b0;
         pref_ref         <= ASEL_NONE;
         rate_sel         <= ASEL_FS44;
         irq_mask         <= 3'h0;
      end else if (wr_en && (avs_address == `ASEL_REG_CTRL)) begin
         auto_follow_mode <= avs_writedata[`ASEL_CTRL_AUTO];
         pref_ref <= asel_src_t'(avs_writedata[`ASEL_CTRL_PREF +: 3]);
         rate_sel <= asel_rate_t'(avs_writedata[`ASEL_CTRL_RATE +: 3]);
      end else if (wr_en && (avs_address == `ASEL_REG_IRQ_MASK)) begin
         irq_mask <= avs_writedata[`ASEL_IRQ_W-1:0];
      end
   end

   always_comb begin
      rd_word = 32'h0000_0000;
      case (avs_address)
         `ASEL_REG_CTRL: begin
            rd_word[`ASEL_CTRL_AUTO]      = auto_follow_mode;
            rd_word[`ASEL_CTRL_PREF +: 3] = pref_ref;
            rd_word[`ASEL_CTRL_RATE +: 3] = rate_sel;
         end
         `ASEL_REG_REF: begin
            rd_word[2:0]                  = active_reference_report;
            rd_word[`ASEL_REF_SLAVE]      = clk_slave;
            rd_word[`ASEL_REF_PAIR]       = pairing_mode;
            rd_word[`ASEL_REF_PER +: 12]  = ref_period;
         end
         `ASEL_REG_SYNC:     rd_word[11:0] = per_input_sync_monitor;
         `ASEL_REG_IRQ_ST:   rd_word[2:0]  = irq_status;
         `ASEL_REG_IRQ_MASK: rd_word[2:0]  = irq_mask;
         default:            rd_word       = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end else if ((avs_read || avs_write) && avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
         avs_readdata    <= avs_read ? rd_word : 32'h0000_0000;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // -------------------------------------------------------------------
   // Checks.
   // -------------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   AST_MASTER_ONLY: assert property (
      !auto_follow_mode |=> !clk_slave
         && (active_reference_report == ASEL_NONE))
      else $error("Master mode left the crystal.");

   AST_RESCAN: assert property (
      auto_follow_mode && (state == ASEL_MASTER) |=> state == ASEL_SCAN)
      else $error("Scanning did not resume.");

   AST_SLAVE_CAUSE: assert property (
      $rose(clk_slave) |-> $past(act_sync && (state == ASEL_FOLLOW)))
      else $error("Slave reported without a matching rate.");

   AST_FIRST_VALID: assert property (
      auto_follow_mode && (state == ASEL_SCAN) && in_valid[cursor]
      |=> (state == ASEL_FOLLOW)
         && (active_reference_report == $past(cursor)))
      else $error("First valid input not taken.");

   AST_REF_PERIOD: assert property (
      src_ok(active_reference_report) |=> ref_period == $past(act_per))
      else $error("Reported frequency does not match reference.");

   AST_PREF_WINS: assert property (
      auto_follow_mode && (state == ASEL_FOLLOW) && pref_ok
      && in_valid[pref_ref] |=> active_reference_report == $past(pref_ref))
      else $error("Valid preferred input not used.");

   AST_FALLBACK: assert property (
      auto_follow_mode && (state == ASEL_SCAN) && !in_valid[cursor]
      && (visited == `ASEL_SCAN_LAST) |=> state == ASEL_MASTER)
      else $error("No fall back to master after a full scan.");

   AST_ONE_REF: assert property (
      (state != ASEL_FOLLOW) |-> active_reference_report == ASEL_NONE)
      else $error("Reference held outside follow state.");

   AST_PAIR: assert property (
      ##1 pairing_mode == $past(pref_ok && is_opt(pref_ref)
         && ((rate_sel == ASEL_FS88) || (rate_sel == ASEL_FS96))))
      else $error("Pairing mode does not follow rate and preference.");

   AST_SCAN_ORDER: assert property (
      auto_follow_mode && (state == ASEL_SCAN) && !in_valid[cursor]
      && (visited != `ASEL_SCAN_LAST)
      |=> cursor == next_src($past(cursor)))
      else $error("Scan order broken.");

endmodule : asel_source_selector

// [dv/asel_src_model.sv]
`timescale 1ns/1ps

// --------
// Frame clocks of the external gear, one per input.
// --------
module asel_src_model (
   input  wire logic [11:0] per [6],
   output logic [5:0]       line
);
   genvar i;
   for (i = 0; i < 6; i++) begin : g_src
      initial begin
         line[i] = 1'b0;
         #(13 * i + 7);
         forever begin
            if (per[i] == 12'h000) begin
               line[i] = 1'b0;
               #20;
            end else begin
               line[i] = 1'b1;
               #(per[i] * 10);
               line[i] = 1'b0;
               #(per[i] * 10);
            end
         end
      end
   end
endmodule : asel_src_model

// [dv/test_asel_source_selector.sv]
`timescale 1ns/1ps
`include "asel_defs.svh"

module test_asel_source_selector;
   import asel_pkg::*;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic [4:0]  avs_address = 5'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        irq;
   logic        clk_slave;
   asel_src_t   active_reference_report;
   logic [11:0] ref_period;
   logic [11:0] per_input_sync_monitor;
   logic        pairing_mode;
   logic [5:0]  line;
   logic [11:0] per [6] = '{default: 12'h000};
   logic [31:0] rd;
   logic [7:0]  rnd = 8'h5c;
   logic [11:0] v;
   int          error_cnt = 0;
   int          checks = 0;

   always #10 sys_clk = ~sys_clk;

   asel_src_model src_u (.per(per), .line(line));

   asel_source_selector dut_u (
      .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .optical_input_one(line[0]), .optical_input_two(line[1]),
      .optical_input_three(line[2]), .spdif_in(line[3]),
      .word_clock_in(line[4]), .sync_port(line[5]), .irq(irq),
      .clk_slave(clk_slave),
      .active_reference_report(active_reference_report),
      .ref_period(ref_period),
      .per_input_sync_monitor(per_input_sync_monitor),
      .pairing_mode(pairing_mode)
   );

   // --------
   // Expectations and checking.
   // --------
   function logic [7:0] lfsr(input logic [7:0] s);
      lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   function logic [11:0] exp_mon(input int hz, input bit pair);
      int e;
      int lo;
      exp_mon = 12'h000;
      for (int k = 0; k < 6; k++) begin
         e = `ASEL_CLK_HZ / hz * ((pair && k < 3) ? 2 : 1);
         lo = (k == 4) ? 486 : 477;
         if (per[k] >= lo && per[k] <= 2000) begin
            exp_mon[2*k +: 2] = (per[k] >= e - 4 && per[k] <= e + 4)
                                ? 2'h3 : 2'h1;
         end
      end
   endfunction : exp_mon

   task give_verdict;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : give_verdict

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk

   task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      rd = avs_readdata;
      if (avs_waitrequest !== 1'b0) begin
         error_cnt++;
         give_verdict;
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task wt(input bit mon, input logic [11:0] e);
      int n;
      n = 0;
      while ((mon ? per_input_sync_monitor
                  : 12'(active_reference_report)) !== e && n < 20000) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 20000) begin
         error_cnt++;
         give_verdict;
      end
      repeat (4) @(posedge sys_clk);
   endtask : wt

   task setp(input int k, input logic [11:0] p);
      per[k] <= p;
      @(posedge sys_clk);
   endtask : setp

   task tdone(input string s);
      $display("test %s done, errors %0d", s, error_cnt);
   endtask : tdone

   // --------
   // Scenarios.
   // --------
   initial begin
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      bus(0, `ASEL_REG_CTRL, 32'h0);
      chk(rd, 32'h1e);
      chk(32'(active_reference_report), 32'(ASEL_NONE));
      bus(0, 5'h1c, 32'h0);
      chk(rd, 32'h0);
      tdone("reset");
      setp(1, 12'd1134);
      wt(1, exp_mon(44100, 0));
      chk(32'(clk_slave), 32'h0);
      tdone("master");
      bus(1, `ASEL_REG_IRQ_MASK, 32'h1);
      bus(1, `ASEL_REG_CTRL, 32'h1f);
      wt(0, 12'(ASEL_OPT2));
      chk(32'(active_reference_report), 32'(ASEL_OPT2));
      chk(32'(clk_slave), 32'h1);
      chk(32'(ref_period >= 1132 && ref_period <= 1136), 32'h1);
      chk(32'(irq), 32'h1);
      bus(0, `ASEL_REG_REF, 32'h0);
      chk(32'(rd[4:0]), 32'h09);
      chk(32'(rd[27:16] >= 1132 && rd[27:16] <= 1136), 32'h1);
      bus(1, `ASEL_REG_IRQ_ST, 32'h1);
      bus(0, `ASEL_REG_IRQ_ST, 32'h0);
      chk(32'(rd[0]), 32'h0);
      chk(32'(irq), 32'h0);
      bus(1, `ASEL_REG_IRQ_MASK, 32'h0);
      setp(3, 12'd1134);
      setp(4, 12'd480);
      setp(5, 12'd480);
      rnd = lfsr(rnd);
      v = 12'd500 + 12'(rnd) * 12'd5;
      if (v > 12'd1120 && v < 12'd1150)
         v = v + 12'd40;
      setp(2, v);
      wt(1, exp_mon(44100, 0));
      chk(32'(per_input_sync_monitor), 32'(exp_mon(44100, 0)));
      bus(0, `ASEL_REG_SYNC, 32'h0);
      chk(rd, 32'(exp_mon(44100, 0)));
      chk(32'(active_reference_report), 32'(ASEL_OPT2));
      tdone("follow");
      bus(1, `ASEL_REG_CTRL, 32'h17);
      wt(0, 12'(ASEL_SPDIF));
      chk(32'(active_reference_report), 32'(ASEL_SPDIF));
      avs_byteenable <= 4'he;
      bus(1, `ASEL_REG_CTRL, 32'h1e);
      avs_byteenable <= 4'hf;
      bus(0, `ASEL_REG_CTRL, 32'h0);
      chk(rd, 32'h17);
      setp(3, 12'd0);
      wt(0, 12'(ASEL_SYNCP));
      chk(32'(active_reference_report), 32'(ASEL_SYNCP));
      chk(32'(clk_slave), 32'h0);
      tdone("preferred");
      for (int k = 0; k < 6; k++)
         setp(k, 12'd0);
      wt(1, 12'h000);
      wt(0, 12'(ASEL_NONE));
      chk(32'(clk_slave), 32'h0);
      chk(32'(ref_period), 32'h0);
      tdone("fallback");
      bus(1, `ASEL_REG_CTRL, 32'h41);
      repeat (2) @(posedge sys_clk);
      chk(32'(pairing_mode), 32'h1);
      setp(0, 12'd1041);
      setp(3, 12'd520);
      wt(1, exp_mon(96000, 1));
      chk(32'(per_input_sync_monitor), 32'(exp_mon(96000, 1)));
      wt(0, 12'(ASEL_OPT1));
      chk(32'(clk_slave), 32'h1);
      bus(1, `ASEL_REG_CTRL, 32'h37);
      repeat (2) @(posedge sys_clk);
      chk(32'(pairing_mode), 32'h0);
      wt(1, exp_mon(88200, 0));
      chk(32'(per_input_sync_monitor), 32'(exp_mon(88200, 0)));
      bus(1, `ASEL_REG_CTRL, 32'h27);
      wt(1, exp_mon(48000, 0));
      chk(32'(per_input_sync_monitor), 32'(exp_mon(48000, 0)));
      chk(32'(clk_slave), 32'h0);
      tdone("pairing");
      give_verdict;
   end
endmodule : test_asel_source_selector
